// *** hdl/pulse_period_accumulator.v ***
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ppa_consts.vh"

module pulse_period_accumulator #(
    parameter W = 24,
    parameter AW = 8
) (
    // Clock, reset and enable
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [AW-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Measured input and timebases
    input wire signal_i,
    input wire primary_timebase_tick_i,
    input wire secondary_timebase_tick_i,
    // Completion flags
    output reg channel_irq_flag_o,
    output reg dma_request_o
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ACTIVE = 2'b01;
    localparam ST_GAP = 2'b10;
    localparam ST_INVALID = 2'b11;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [`PPA_CTRL_WIDTH-1:0] ctrl_reg;
    reg [W-1:0] running_total_reg;
    reg [7:0] running_overflow_flags_reg;
    reg [W-1:0] interim_update_interval_reg;
    reg [W-1:0] previous_edge_stamp_reg;
    reg [W-1:0] elapsed_cycle_tally_reg;
    reg [W-1:0] target_cycle_tally_reg;
    reg [W-1:0] completed_total_reg;
    reg [7:0] completed_overflow_flags_reg;
    reg [W-1:0] timebase_now_reg;
    reg [1:0] state_reg;
    reg [W-1:0] pend_total_reg;
    reg [7:0] pend_ovf_reg;
    reg [`PPA_PUB_STAGES-1:0] pub_stage_reg;

    reg [1:0] state_next;
    reg [31:0] rd_next;
    reg map_hit;

    wire [1:0] mode = ctrl_reg[`PPA_CTRL_MODE_MSB:`PPA_CTRL_MODE_LSB];
    wire enabled = ctrl_reg[`PPA_CTRL_EN_BIT];
    wire tb_sel = ctrl_reg[`PPA_CTRL_TB_BIT];
    wire tb_tick = tb_sel ? secondary_timebase_tick_i : primary_timebase_tick_i;

    wire setup = psel_i & ~penable_i;
    wire wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
    wire [7:0] waddr = paddr_i[7:0];

    // ----------------------------------------
    // Edge classification
    // ----------------------------------------
    wire rise;
    wire fall;

    ppa_edge_detect u_edges (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .sig_i(signal_i),
        .rise_o(rise),
        .fall_o(fall)
    );

    reg seg_start;
    reg seg_end;
    wire is_period = mode[1];

    always @* begin
        case (mode)
            `PPA_MODE_HIGH: begin
                seg_start = rise;
                seg_end = fall;
            end
            `PPA_MODE_LOW: begin
                seg_start = fall;
                seg_end = rise;
            end
            `PPA_MODE_PER_RISE: begin
                seg_start = rise;
                seg_end = rise;
            end
            default: begin
                seg_start = fall;
                seg_end = fall;
            end
        endcase
    end

    // ----------------------------------------
    // Interim update timer
    // ----------------------------------------
    wire begin_seg = enabled && seg_start && (state_reg == ST_IDLE || state_reg == ST_GAP);
    wire end_seg = enabled && seg_end && state_reg == ST_ACTIVE;
    wire interim_fire;
    wire timer_start = begin_seg | (end_seg & is_period);
    wire timer_stop = (end_seg & ~is_period) | ~enabled | (state_reg == ST_INVALID);

    ppa_interval_timer #(
        .W(W)
    ) u_timer (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .tick_i(tb_tick),
        .start_i(timer_start),
        .stop_i(timer_stop),
        .interval_i(interim_update_interval_reg),
        .fire_o(interim_fire)
    );

    // ----------------------------------------
    // Accumulation arithmetic
    // ----------------------------------------
    wire [W-1:0] delta = timebase_now_reg - previous_edge_stamp_reg;
    wire [W:0] sum = {1'b0, running_total_reg} + {1'b0, delta};
    wire [7:0] ovf_new = running_overflow_flags_reg | (sum[W] ? `PPA_OVF_CARRY : `PPA_OVF_RESET);
    wire [W-1:0] tally_inc = elapsed_cycle_tally_reg + {{(W-1){1'b0}}, 1'b1};
    wire done = end_seg && (tally_inc >= target_cycle_tally_reg);
    // The timer pulses on the tick that closes each interval, so updates keep the programmed spacing
    wire interim = interim_fire && state_reg == ST_ACTIVE && !end_seg;

    // A host write that alters mode or timebase mid measurement is caught here
    wire ctrl_wr = wr_en && waddr == `PPA_ADDR_CTRL;
    wire [1:0] new_mode = pwdata_i[`PPA_CTRL_MODE_MSB:`PPA_CTRL_MODE_LSB];
    wire busy = state_reg == ST_ACTIVE || state_reg == ST_GAP;
    wire bad_mode = ctrl_wr && busy && pwdata_i[`PPA_CTRL_EN_BIT] && new_mode != mode;
    wire bad_tb = ctrl_wr && busy && pwdata_i[`PPA_CTRL_EN_BIT] && pwdata_i[`PPA_CTRL_TB_BIT] != tb_sel;

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = begin_seg ? ST_ACTIVE : ST_IDLE;
            ST_ACTIVE: state_next = (end_seg && !is_period) ? ST_GAP : ST_ACTIVE;
            ST_GAP: state_next = begin_seg ? ST_ACTIVE : ST_GAP;
            ST_INVALID: state_next = ST_INVALID;
            default: state_next = ST_IDLE;
        endcase
        // Invalid is left only by clearing enable
        if (bad_mode || bad_tb) begin
            state_next = ST_INVALID;
        end
        if (!enabled) begin
            state_next = ST_IDLE;
        end
    end

    // ----------------------------------------
    // Timebase and measurement datapath
    // ----------------------------------------
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= `PPA_CTRL_RESET;
            state_reg <= ST_IDLE;
            timebase_now_reg <= {W{1'b0}};
            running_total_reg <= {W{1'b0}};
            running_overflow_flags_reg <= `PPA_OVF_RESET;
            interim_update_interval_reg <= {W{1'b0}};
            previous_edge_stamp_reg <= {W{1'b0}};
            elapsed_cycle_tally_reg <= {W{1'b0}};
            target_cycle_tally_reg <= {W{1'b0}};
            pend_total_reg <= {W{1'b0}};
            pend_ovf_reg <= `PPA_OVF_RESET;
        end else if (ce_i) begin
            state_reg <= state_next;
            if (tb_tick) begin
                timebase_now_reg <= timebase_now_reg + {{(W-1){1'b0}}, 1'b1};
            end
            // Host setup writes; device updates below take precedence
            if (wr_en) begin
                case (waddr)
                    `PPA_ADDR_CTRL: ctrl_reg <= pwdata_i[`PPA_CTRL_WIDTH-1:0];
                    `PPA_ADDR_RUN_TOTAL: running_total_reg <= pwdata_i[W-1:0];
                    `PPA_ADDR_RUN_OVF: running_overflow_flags_reg <= pwdata_i[7:0];
                    `PPA_ADDR_INTERVAL: interim_update_interval_reg <= pwdata_i[W-1:0];
                    `PPA_ADDR_TALLY: elapsed_cycle_tally_reg <= pwdata_i[W-1:0];
                    `PPA_ADDR_TARGET: target_cycle_tally_reg <= pwdata_i[W-1:0];
                    default: ;
                endcase
            end
            if (begin_seg) begin
                previous_edge_stamp_reg <= timebase_now_reg;
            end
            if (interim) begin
                running_total_reg <= sum[W-1:0];
                running_overflow_flags_reg <= ovf_new;
                previous_edge_stamp_reg <= timebase_now_reg;
            end
            if (end_seg) begin
                previous_edge_stamp_reg <= timebase_now_reg;
                if (done) begin
                    pend_total_reg <= sum[W-1:0];
                    pend_ovf_reg <= ovf_new;
                    running_total_reg <= {W{1'b0}};
                    running_overflow_flags_reg <= `PPA_OVF_RESET;
                    elapsed_cycle_tally_reg <= {W{1'b0}};
                end else begin
                    running_total_reg <= sum[W-1:0];
                    running_overflow_flags_reg <= ovf_new;
                    elapsed_cycle_tally_reg <= tally_inc;
                end
            end
            if (bad_mode) begin
                running_overflow_flags_reg <= running_overflow_flags_reg | `PPA_OVF_BAD_MODE;
            end
            if (bad_tb) begin
                running_overflow_flags_reg <= running_overflow_flags_reg | `PPA_OVF_BAD_TB |
                    (bad_mode ? `PPA_OVF_BAD_MODE : `PPA_OVF_RESET);
            end
        end
    end

    // ----------------------------------------
    // Publication sequence
    // ----------------------------------------
    // Three steps so that the overflow flag is never newer than its total
    // when the host reacts to the flags
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pub_stage_reg <= {`PPA_PUB_STAGES{1'b0}};
            completed_total_reg <= {W{1'b0}};
            completed_overflow_flags_reg <= `PPA_OVF_RESET;
            channel_irq_flag_o <= 1'b0;
            dma_request_o <= 1'b0;
        end else if (ce_i) begin
            pub_stage_reg <= {pub_stage_reg[`PPA_PUB_STAGES-2:0], done};
            if (pub_stage_reg[0]) begin
                completed_total_reg <= pend_total_reg;
            end
            if (pub_stage_reg[1]) begin
                completed_overflow_flags_reg <= pend_ovf_reg;
            end
            // Write one to clear; a new completion in the same cycle wins
            if (wr_en && waddr == `PPA_ADDR_EVENTS) begin
                if (pwdata_i[`PPA_EVT_IRQ_BIT]) begin
                    channel_irq_flag_o <= 1'b0;
                end
                if (pwdata_i[`PPA_EVT_DMA_BIT]) begin
                    dma_request_o <= 1'b0;
                end
            end
            if (pub_stage_reg[2]) begin
                channel_irq_flag_o <= 1'b1;
                dma_request_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // APB read decode
    // ----------------------------------------
    always @* begin
        rd_next = 32'h0000_0000;
        map_hit = 1'b1;
        case (paddr_i[7:0])
            `PPA_ADDR_CTRL: rd_next[`PPA_CTRL_WIDTH-1:0] = ctrl_reg;
            `PPA_ADDR_RUN_TOTAL: rd_next[W-1:0] = running_total_reg;
            `PPA_ADDR_RUN_OVF: rd_next[7:0] = running_overflow_flags_reg;
            `PPA_ADDR_INTERVAL: rd_next[W-1:0] = interim_update_interval_reg;
            `PPA_ADDR_TALLY: rd_next[W-1:0] = elapsed_cycle_tally_reg;
            `PPA_ADDR_TARGET: rd_next[W-1:0] = target_cycle_tally_reg;
            `PPA_ADDR_DONE_TOTAL: rd_next[W-1:0] = completed_total_reg;
            `PPA_ADDR_DONE_OVF: rd_next[7:0] = completed_overflow_flags_reg;
            `PPA_ADDR_EVENTS: begin
                rd_next[`PPA_EVT_IRQ_BIT] = channel_irq_flag_o;
                rd_next[`PPA_EVT_DMA_BIT] = dma_request_o;
            end
            default: map_hit = 1'b0;
        endcase
        if (paddr_i[1:0] != 2'b00) begin
            map_hit = 1'b0;
        end
        // Addresses beyond the eight-bit map are refused rather than aliased
        if (|(paddr_i >> 4'h8)) begin
            map_hit = 1'b0;
        end
        if (!map_hit) begin
            rd_next = 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // Fixed one wait-free access cycle: ready rises in the first access cycle
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= setup;
            if (setup) begin
                pslverr_o <= ~map_hit;
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_next;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** hdl/ppa_consts.vh ***
`ifndef PPA_CONSTS_VH
`define PPA_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PPA_ADDR_CTRL 8'h00
`define PPA_ADDR_RUN_TOTAL 8'h04
`define PPA_ADDR_RUN_OVF 8'h08
`define PPA_ADDR_INTERVAL 8'h0c
`define PPA_ADDR_TALLY 8'h10
`define PPA_ADDR_TARGET 8'h14
`define PPA_ADDR_DONE_TOTAL 8'h18
`define PPA_ADDR_DONE_OVF 8'h1c
`define PPA_ADDR_EVENTS 8'h20

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PPA_CTRL_EN_BIT 0
`define PPA_CTRL_MODE_LSB 1
`define PPA_CTRL_MODE_MSB 2
`define PPA_CTRL_TB_BIT 3
`define PPA_CTRL_WIDTH 4
`define PPA_CTRL_RESET 4'h0

// ----------------------------------------
// Measurement modes
// ----------------------------------------
`define PPA_MODE_HIGH 2'h0
`define PPA_MODE_LOW 2'h1
`define PPA_MODE_PER_RISE 2'h2
`define PPA_MODE_PER_FALL 2'h3

// ----------------------------------------
// Overflow flag values and event bits
// ----------------------------------------
`define PPA_OVF_CARRY 8'h80
`define PPA_OVF_BAD_MODE 8'h01
`define PPA_OVF_BAD_TB 8'h02
`define PPA_OVF_RESET 8'h00
`define PPA_EVT_IRQ_BIT 0
`define PPA_EVT_DMA_BIT 1
`define PPA_PUB_STAGES 3

`endif

// *** hdl/ppa_edge_detect.v ***
`timescale 1ns/1ps
`default_nettype none

module ppa_edge_detect (
    // Clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    // Measured signal
    input wire sig_i,
    // Edge pulses
    output wire rise_o,
    output wire fall_o
);

    reg prev_reg;
    reg primed_reg;

    // No edge is reported until one real sample has been taken
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_reg <= 1'b0;
            primed_reg <= 1'b0;
        end else if (ce_i) begin
            prev_reg <= sig_i;
            primed_reg <= 1'b1;
        end
    end

    assign rise_o = ce_i & primed_reg & sig_i & ~prev_reg;
    assign fall_o = ce_i & primed_reg & ~sig_i & prev_reg;

endmodule

`default_nettype wire

// *** hdl/ppa_interval_timer.v ***
`timescale 1ns/1ps
`default_nettype none

module ppa_interval_timer #(
    parameter W = 24
) (
    // Clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    // Control
    input wire tick_i,
    input wire start_i,
    input wire stop_i,
    input wire [W-1:0] interval_i,
    // Expiry pulse
    output reg fire_o
);

    reg [W-1:0] count_reg;
    reg run_reg;

    // Fire is combinational so the update lands on the tick that ends the interval
    always @* begin
        fire_o = ce_i & ~stop_i & ~start_i & run_reg & tick_i & (count_reg == {{(W-1){1'b0}}, 1'b1});
    end

    // A zero interval leaves the timer idle, so interim updates are off
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= {W{1'b0}};
            run_reg <= 1'b0;
        end else if (ce_i) begin
            if (stop_i) begin
                run_reg <= 1'b0;
            end else if (start_i) begin
                run_reg <= |interval_i;
                count_reg <= interval_i;
            end else if (run_reg && tick_i) begin
                if (count_reg == {{(W-1){1'b0}}, 1'b1}) begin
                    count_reg <= interval_i;
                end else begin
                    count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** test/pulse_period_accumulator_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppa_consts.vh"
module ppa_chk #(
    parameter W = 24,
    parameter AW = 8
) (
    // Clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    input wire ce_i,
    // APB
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [AW-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // Measurement
    input wire signal_i,
    input wire primary_timebase_tick_i,
    input wire secondary_timebase_tick_i,
    input wire channel_irq_flag_o,
    input wire dma_request_o
);
logic sig_d;
logic [3:0] quiet_cnt;
wire ev_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `PPA_ADDR_EVENTS;
// Completion may only follow an input edge, so count cycles since the last one
always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        sig_d <= 1'b0;
        quiet_cnt <= 4'hf;
    end else begin
        sig_d <= signal_i;
        if (signal_i != sig_d)
            quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hf)
            quiet_cnt <= quiet_cnt + 4'h1;
    end
end
default clocking cb @(posedge mclk_i); endclocking
default disable iff (!reset_n_i);
sequence setup_s;
    psel_i && !penable_i && ce_i;
endsequence
sequence access_s;
    psel_i && penable_i && pready_o;
endsequence
a_ready_after_setup: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
a_ready_one_cycle: assert property (access_s |=> !pready_o)
    else $error("ready held too long");
a_ready_has_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
a_err_data_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
    else $error("error read data not zero");
a_upper_bits_zero: assert property (pready_o |-> prdata_o[31:24] == 8'h00)
    else $error("read data above 24 bits");
a_irq_sticky: assert property (channel_irq_flag_o && !(ev_wr && pwdata_i[0]) |=> channel_irq_flag_o)
    else $error("interrupt flag dropped");
a_dma_sticky: assert property (dma_request_o && !(ev_wr && pwdata_i[1]) |=> dma_request_o)
    else $error("dma flag dropped");
a_flags_together: assert property ($rose(channel_irq_flag_o) |-> dma_request_o)
    else $error("interrupt without dma request");
a_done_after_edge: assert property ($rose(channel_irq_flag_o) |-> quiet_cnt <= 4'h6)
    else $error("completion without input edge");
endmodule
bind pulse_period_accumulator ppa_chk #(.W(W), .AW(AW)) chk_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .signal_i(signal_i), .primary_timebase_tick_i(primary_timebase_tick_i),
    .secondary_timebase_tick_i(secondary_timebase_tick_i),
    .channel_irq_flag_o(channel_irq_flag_o), .dma_request_o(dma_request_o));
`default_nettype wire

// *** test/ppa_signal_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppa_signal_src (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Pulse shape
    input wire logic run_i,
    input wire logic [7:0] high_len_i,
    input wire logic [7:0] low_len_i,
    // Measured signal
    output logic sig_o
);
logic [7:0] left_reg;
// Idles low when stopped; each phase lasts its length in clocks
always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        sig_o <= 1'b0;
        left_reg <= 8'h00;
    end else if (!run_i) begin
        sig_o <= 1'b0;
        left_reg <= low_len_i - 8'h01;
    end else if (left_reg == 8'h00) begin
        sig_o <= !sig_o;
        left_reg <= (sig_o ? low_len_i : high_len_i) - 8'h01;
    end else begin
        left_reg <= left_reg - 8'h01;
    end
end
endmodule
`default_nettype wire

// *** test/pulse_period_accumulator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppa_consts.vh"
module pulse_period_accumulator_tb_top;
// ----------------------------------------
// Stimulus and observed signals
// ----------------------------------------
logic mclk_i = 1'b0;
logic reset_n_i = 1'b0;
logic psel_i = 1'b0;
logic penable_i = 1'b0;
logic pwrite_i = 1'b0;
logic [7:0] paddr_i = 8'h00;
logic [31:0] pwdata_i = 32'h0;
logic sec_tick = 1'b0;
logic run_sig = 1'b0;
logic [7:0] high_len = 8'h0a;
logic ce = 1'b1;
logic [31:0] prdata_o;
logic pready_o, pslverr_o, signal_i, channel_irq_flag_o, dma_request_o;
int err_count = 0;
int compares = 0;
logic [31:0] mode_exp [4] = '{32'd20, 32'd12, 32'd32, 32'd32};
always #2.5 mclk_i = ~mclk_i;
// Slow timebase: one count every second clock
always @(posedge mclk_i) sec_tick <= ~sec_tick;
pulse_period_accumulator dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .signal_i(signal_i), .primary_timebase_tick_i(1'b1), .secondary_timebase_tick_i(sec_tick),
    .channel_irq_flag_o(channel_irq_flag_o), .dma_request_o(dma_request_o));
ppa_signal_src src_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .run_i(run_sig),
    .high_len_i(high_len), .low_len_i(8'h06), .sig_o(signal_i));
// ----------------------------------------
// Bus and check tasks
// ----------------------------------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                   output logic e);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
        @(posedge mclk_i);
        n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
        err_count++;
        stop_test();
    end else begin
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // One idle edge so the next call never reassigns psel in this time step
        @(posedge mclk_i);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
endtask
task automatic wait_until(input logic lvl, input logic which);
    int n;
    n = 0;
    while ((which ? channel_irq_flag_o : signal_i) !== lvl && n < 3000) begin
        @(posedge mclk_i);
        n++;
    end
    if ((which ? channel_irq_flag_o : signal_i) !== lvl) begin
        err_count++;
        stop_test();
    end
endtask
task automatic start(input logic [1:0] m, input logic tb, input logic [23:0] tgt, input logic [23:0] ivl,
                     input logic [23:0] pre);
    wr(`PPA_ADDR_CTRL, 32'h0);
    wr(`PPA_ADDR_RUN_TOTAL, {8'h0, pre});
    wr(`PPA_ADDR_RUN_OVF, 32'h0);
    wr(`PPA_ADDR_TALLY, 32'h0);
    wr(`PPA_ADDR_INTERVAL, {8'h0, ivl});
    wr(`PPA_ADDR_TARGET, {8'h0, tgt});
    wr(`PPA_ADDR_EVENTS, 32'h3);
    wr(`PPA_ADDR_CTRL, {28'h0, tb, m, 1'b1});
endtask
task automatic stop_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial begin
    logic [31:0] r;
    logic e;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h06, 32'h5, r, e);
    chk({31'h0, e}, 32'h1);
    wr(`PPA_ADDR_DONE_TOTAL, 32'h123);
    rd(`PPA_ADDR_DONE_TOTAL, 32'h0);
    run_sig <= 1'b1;
    for (int m = 0; m < 4; m++) begin
        start(m[1:0], 1'b0, 24'h2, 24'h0, 24'h0);
        wait_until(1'b1, 1'b1);
        rd(`PPA_ADDR_DONE_TOTAL, mode_exp[m]);
        rd(`PPA_ADDR_TALLY, 32'h0);
        chk({31'h0, dma_request_o}, 32'h1);
        wr(`PPA_ADDR_EVENTS, 32'h1);
        chk({30'h0, dma_request_o, channel_irq_flag_o}, 32'h2);
        wr(`PPA_ADDR_EVENTS, 32'h3);
        wait_until(1'b1, 1'b1);
        rd(`PPA_ADDR_DONE_TOTAL, mode_exp[m]);
    end
    start(2'h0, 1'b1, 24'h1, 24'h0, 24'h0);
    wait_until(1'b1, 1'b1);
    rd(`PPA_ADDR_DONE_TOTAL, 32'd5);
    start(2'h0, 1'b0, 24'h1, 24'h0, 24'hfffff8);
    wait_until(1'b1, 1'b1);
    rd(`PPA_ADDR_DONE_TOTAL, 32'd2);
    rd(`PPA_ADDR_DONE_OVF, {24'h0, `PPA_OVF_CARRY});
    rd(`PPA_ADDR_RUN_OVF, 32'h0);
    wr(`PPA_ADDR_EVENTS, 32'h3);
    wait_until(1'b1, 1'b1);
    rd(`PPA_ADDR_DONE_OVF, 32'h0);
    high_len <= 8'd40;
    start(2'h0, 1'b0, 24'h1, 24'h4, 24'h0);
    wait_until(1'b0, 1'b0);
    wait_until(1'b1, 1'b0);
    repeat (20) @(posedge mclk_i);
    apb(1'b0, `PPA_ADDR_RUN_TOTAL, 32'h0, r, e);
    chk({31'h0, r >= 32'd12 && r <= 32'd20 && r[1:0] == 2'h0}, 32'h1);
    start(2'h0, 1'b0, 24'h1, 24'd60, 24'h0);
    wait_until(1'b0, 1'b0);
    wait_until(1'b1, 1'b0);
    // Ten frozen clocks inside the pulse must not be counted
    ce <= 1'b0;
    repeat (10) @(posedge mclk_i);
    ce <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rd(`PPA_ADDR_RUN_TOTAL, 32'h0);
    wait_until(1'b1, 1'b1);
    rd(`PPA_ADDR_DONE_TOTAL, 32'd30);
    start(2'h0, 1'b0, 24'h1, 24'h0, 24'h0);
    wait_until(1'b0, 1'b0);
    wait_until(1'b1, 1'b0);
    wr(`PPA_ADDR_CTRL, 32'h3);
    rd(`PPA_ADDR_RUN_OVF, {24'h0, `PPA_OVF_BAD_MODE});
    start(2'h0, 1'b0, 24'h1, 24'h0, 24'h0);
    wait_until(1'b0, 1'b0);
    wait_until(1'b1, 1'b0);
    wr(`PPA_ADDR_CTRL, 32'h9);
    rd(`PPA_ADDR_RUN_OVF, {24'h0, `PPA_OVF_BAD_TB});
    stop_test();
end
endmodule
`default_nettype wire
